// File: cdp_pkg.sv
// Package: offsets, fields and reset values of the coherent configuration structures
package cdp_pkg;
	localparam logic [11:0] TL_HDR_OFS = 12'h100;
	localparam logic [11:0] TL_HDR1_OFS = 12'h104;
	localparam logic [11:0] TL_CTRL_OFS = 12'h108;
	localparam logic [11:0] PL_HDR_OFS = 12'h140;
	localparam logic [11:0] PL_HDR1_OFS = 12'h144;
	localparam logic [11:0] PL_HDR2_OFS = 12'h148;
	localparam logic [11:0] PL_PTR_OFS = 12'h14c;
	localparam logic [11:0] CAP_BASE_OFS = 12'h160;
	localparam logic [11:0] CAP_COMMON_OFS = 12'h160;
	localparam logic [11:0] STAT_RO_OFS = 12'h164;
	localparam logic [11:0] CAP_CHIP_OFS = 12'h168;
	localparam logic [11:0] CTRL_BASE_OFS = 12'h180;
	localparam logic [11:0] CTRL_PORT_OFS = 12'h180;
	localparam logic [11:0] STAT_RW_OFS = 12'h184;
	localparam logic [11:0] CTRL_COMMON_OFS = 12'h188;
	localparam logic [11:0] CTRL_SAM_OFS = 12'h18c;
	localparam logic [11:0] AGENT0_HDR_OFS = 12'h100;
	localparam logic [11:0] AGENT0_HDR1_OFS = 12'h104;
	localparam logic [11:0] AGENT1_HDR_OFS = 12'h110;
	localparam logic [11:0] AGENT1_HDR1_OFS = 12'h114;
	localparam logic [11:0] NEXT_NONE = 12'h000;
	localparam logic [15:0] EXT_CAP_ID = 16'h0023;
	localparam logic [3:0] CAP_VERSION = 4'h1;
	localparam logic [3:0] STRUCT_REVISION = 4'h1;
	localparam logic [15:0] PL_COMPONENT_ID = 16'h0002;
	localparam logic [15:0] TL_COMPONENT_ID = 16'h0001;
	localparam logic [15:0] AGENT_COMPONENT_ID = 16'h0003;
	localparam logic [11:0] TL_LENGTH = 12'h00c;
	localparam logic [11:0] PL_LENGTH = 12'h050;
	localparam logic [11:0] AGENT_LENGTH = 12'h008;
	localparam int CAP_ID_LSB = 0;
	localparam int VER_LSB = 16;
	localparam int NEXT_LSB = 20;
	localparam int REV_LSB = 16;
	localparam int LEN_LSB = 20;
	localparam int CTRL_PTR_LSB = 16;
	localparam int PRIMARY_CAP_BIT = 0;
	localparam int PORT_CNT_LSB = 4;
	localparam int PRIMARY_EN_BIT = 0;
	localparam int ERR_EVT_BIT = 0;
	localparam int FLR_EVT_BIT = 1;
	localparam logic [31:0] CTRL_RESET = 32'h0000_0000;
	localparam logic [31:0] SAM_RESET = 32'h0000_0000;
	localparam logic [31:0] TL_CTRL_RESET = 32'h0000_0000;
endpackage

// File: cdp_config_bank.sv
// Configuration structure register bank of one coherency-capable port, on APB
//
// The register offsets and the APB slave port are this design's own decisions.
`timescale 1ns/1ps
module cdp_config_bank #(
	parameter logic [15:0] CONSORTIUM_ID = 16'h1e2c, // Arbitrary value
	parameter logic PRIMARY_CAPABLE = 1'b1,
	parameter logic [3:0] PORT_COUNT = 4'h1,
	parameter logic IS_BRIDGE_OR_COLLECTOR = 1'b0,
	parameter int FUNC_BITS = 8,
	parameter logic [7:0] AGENT_FUNC = 8'h01
) (
	input wire logic ref_clk,
	input wire logic resetn,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [19:0] paddr,
	input wire logic [31:0] pwdata,
	input wire logic [3:0] pstrb,
	input wire logic vfAccess,
	input wire logic flrReq,
	input wire logic linkErrEvt,
	input wire logic [7:0] linkStatus,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	output logic primaryEnable,
	output logic [31:0] portControl,
	output logic [31:0] systemAddressMapBase
);

	logic preadyQ;
	logic pslverrQ;
	logic [31:0] prdataQ;
	logic [31:0] tlCtrlQ;
	logic [31:0] portCtrlQ;
	logic [31:0] commonCtrlQ;
	logic [31:0] samBaseQ;
	logic [1:0] rwStatusQ;
	logic [31:0] rdData;
	logic rdHit;
	logic rwHit;
	logic [FUNC_BITS-1:0] funcNum;
	logic [11:0] cfgOfs;
	logic isFunc0;
	logic isAgentFunc;
	logic access;
	logic doWrite;
	logic [31:0] byteMask;

	assign funcNum = paddr[12+FUNC_BITS-1:12];
	assign cfgOfs = paddr[11:0];
	assign isFunc0 = (funcNum == '0) && !vfAccess && !IS_BRIDGE_OR_COLLECTOR;
	// only function AGENT_FUNC, which may be any of 1 to 255, holds agents; function 0 decodes first
	assign isAgentFunc = (funcNum == AGENT_FUNC[FUNC_BITS-1:0]) && !vfAccess && !IS_BRIDGE_OR_COLLECTOR;
	assign access = psel && penable && !preadyQ;
	assign doWrite = psel && penable && preadyQ && pwrite && !pslverrQ;
	assign byteMask = {{8{pstrb[3]}}, {8{pstrb[2]}}, {8{pstrb[1]}}, {8{pstrb[0]}}};

	// one field kind per dword
	// Read decode; headers are constants so the host sees fixed identity
	always_comb begin
		rdData = 32'h0000_0000;
		rdHit = 1'b0;
		rwHit = 1'b0;
		if (isFunc0) begin
			case (cfgOfs)
				// transport header; links to protocol header; version
				cdp_pkg::TL_HDR_OFS: begin
					rdData = {cdp_pkg::PL_HDR_OFS, cdp_pkg::CAP_VERSION, cdp_pkg::EXT_CAP_ID};
					rdHit = 1'b1;
				end
				cdp_pkg::TL_HDR1_OFS: begin
					rdData = {cdp_pkg::TL_LENGTH, cdp_pkg::STRUCT_REVISION, CONSORTIUM_ID};
					rdHit = 1'b1;
				end
				cdp_pkg::TL_CTRL_OFS: begin
					rdData = tlCtrlQ;
					rdHit = 1'b1;
					rwHit = 1'b1;
				end
				cdp_pkg::PL_HDR_OFS: begin
					rdData = {cdp_pkg::NEXT_NONE, cdp_pkg::CAP_VERSION, cdp_pkg::EXT_CAP_ID};
					rdHit = 1'b1;
				end
				cdp_pkg::PL_HDR1_OFS: begin
					rdData = {cdp_pkg::PL_LENGTH, cdp_pkg::STRUCT_REVISION, CONSORTIUM_ID};
					rdHit = 1'b1;
				end
				cdp_pkg::PL_HDR2_OFS: begin
					rdData = {16'h0000, cdp_pkg::PL_COMPONENT_ID};
					rdHit = 1'b1;
				end
				// separate region offsets; absolute in config space
				cdp_pkg::PL_PTR_OFS: begin
					rdData = {4'h0, cdp_pkg::CTRL_BASE_OFS, 4'h0, cdp_pkg::CAP_BASE_OFS};
					rdHit = 1'b1;
				end
				cdp_pkg::CAP_COMMON_OFS: begin
					rdData = {24'h00_0000, PORT_COUNT, 3'h0, PRIMARY_CAPABLE};
					rdHit = 1'b1;
				end
				cdp_pkg::STAT_RO_OFS: begin
					rdData = {24'h00_0000, linkStatus};
					rdHit = 1'b1;
				end
				// chip-level capability only on primary-capable port
				cdp_pkg::CAP_CHIP_OFS: begin
					rdData = {31'h0000_0000, PRIMARY_CAPABLE};
					rdHit = PRIMARY_CAPABLE;
				end
				cdp_pkg::CTRL_PORT_OFS: begin
					rdData = portCtrlQ;
					rdHit = 1'b1;
					rwHit = 1'b1;
				end
				cdp_pkg::STAT_RW_OFS: begin
					rdData = {30'h0000_0000, rwStatusQ};
					rdHit = 1'b1;
					rwHit = 1'b1;
				end
				cdp_pkg::CTRL_COMMON_OFS: begin
					rdData = commonCtrlQ;
					rdHit = PRIMARY_CAPABLE;
					rwHit = PRIMARY_CAPABLE;
				end
				cdp_pkg::CTRL_SAM_OFS: begin
					rdData = samBaseQ;
					rdHit = PRIMARY_CAPABLE;
					rwHit = PRIMARY_CAPABLE;
				end
				default: begin
					rdData = 32'h0000_0000;
				end
			endcase
		end else if (isAgentFunc) begin
			case (cfgOfs)
				// two agent structures in one function
				cdp_pkg::AGENT0_HDR_OFS: begin
					rdData = {cdp_pkg::AGENT1_HDR_OFS, cdp_pkg::CAP_VERSION, cdp_pkg::EXT_CAP_ID};
					rdHit = 1'b1;
				end
				cdp_pkg::AGENT0_HDR1_OFS,
				cdp_pkg::AGENT1_HDR1_OFS: begin
					rdData = {cdp_pkg::AGENT_LENGTH, cdp_pkg::STRUCT_REVISION, CONSORTIUM_ID};
					rdHit = 1'b1;
				end
				cdp_pkg::AGENT1_HDR_OFS: begin
					rdData = {cdp_pkg::NEXT_NONE, cdp_pkg::CAP_VERSION, cdp_pkg::EXT_CAP_ID};
					rdHit = 1'b1;
				end
				default: begin
					rdData = 32'h0000_0000;
				end
			endcase
		end
	end

	// Answer one cycle into the access phase; errors for unmapped or read-only writes
	always_ff @(posedge ref_clk or negedge resetn) begin
		if (!resetn) begin
			preadyQ <= 1'b0;
			pslverrQ <= 1'b0;
			prdataQ <= 32'h0000_0000;
		end else if (access) begin
			preadyQ <= 1'b1;
			pslverrQ <= !rdHit || (pwrite && !rwHit);
			prdataQ <= pwrite ? 32'h0000_0000 : rdData;
		end else begin
			preadyQ <= 1'b0;
			pslverrQ <= 1'b0;
		end
	end

	// no FLR term: contents survive a function level reset
	always_ff @(posedge ref_clk or negedge resetn) begin
		if (!resetn) begin
			tlCtrlQ <= cdp_pkg::TL_CTRL_RESET;
		end else if (doWrite && isFunc0 && cfgOfs == cdp_pkg::TL_CTRL_OFS) begin
			tlCtrlQ <= (tlCtrlQ & ~byteMask) | (pwdata & byteMask);
		end
	end

	// software's primary choice steers chip-level logic
	always_ff @(posedge ref_clk or negedge resetn) begin
		if (!resetn) begin
			portCtrlQ <= cdp_pkg::CTRL_RESET;
		end else if (doWrite && isFunc0 && cfgOfs == cdp_pkg::CTRL_PORT_OFS) begin
			portCtrlQ <= (portCtrlQ & ~byteMask) | (pwdata & byteMask);
		end
	end

	always_ff @(posedge ref_clk or negedge resetn) begin
		if (!resetn) begin
			commonCtrlQ <= cdp_pkg::CTRL_RESET;
			samBaseQ <= cdp_pkg::SAM_RESET;
		end else if (doWrite && isFunc0 && PRIMARY_CAPABLE) begin
			if (cfgOfs == cdp_pkg::CTRL_COMMON_OFS) begin
				commonCtrlQ <= (commonCtrlQ & ~byteMask) | (pwdata & byteMask);
			end
			if (cfgOfs == cdp_pkg::CTRL_SAM_OFS) begin
				samBaseQ <= (samBaseQ & ~byteMask) | (pwdata & byteMask);
			end
		end
	end

	// write-one-to-clear status; a new event wins over the clear
	always_ff @(posedge ref_clk or negedge resetn) begin
		if (!resetn) begin
			rwStatusQ <= 2'b00;
		end else begin
			for (int i = 0; i < 2; i++) begin
				if ((i == cdp_pkg::ERR_EVT_BIT && linkErrEvt) || (i == cdp_pkg::FLR_EVT_BIT && flrReq)) begin
					rwStatusQ[i] <= 1'b1;
				end else if (doWrite && isFunc0 && cfgOfs == cdp_pkg::STAT_RW_OFS && pstrb[0] && pwdata[i]) begin
					rwStatusQ[i] <= 1'b0;
				end
			end
		end
	end

	// primaryEnable and systemAddressMapBase act only when this port is primary-capable and enabled; portControl always copies the port control dword
	always_ff @(posedge ref_clk or negedge resetn) begin
		if (!resetn) begin
			primaryEnable <= 1'b0;
			portControl <= cdp_pkg::CTRL_RESET;
			systemAddressMapBase <= cdp_pkg::SAM_RESET;
		end else begin
			primaryEnable <= PRIMARY_CAPABLE && portCtrlQ[cdp_pkg::PRIMARY_EN_BIT];
			portControl <= portCtrlQ;
			systemAddressMapBase <= (PRIMARY_CAPABLE && portCtrlQ[cdp_pkg::PRIMARY_EN_BIT]) ? samBaseQ : 32'h0000_0000;
		end
	end

	assign prdata = prdataQ;
	assign pready = preadyQ;
	assign pslverr = pslverrQ;

	property p_version_one;
		@(posedge ref_clk) disable iff (!resetn)
		(pready && !pwrite && !pslverr && $past(isFunc0) && $past(cfgOfs) == cdp_pkg::PL_HDR_OFS)
			|-> prdata[19:16] == 4'h1;
	endproperty
	a_version_one: assert property (p_version_one) else $error("Version field not 1h");

	property p_rev_vendor;
		@(posedge ref_clk) disable iff (!resetn)
		(pready && !pwrite && $past(isFunc0) && $past(cfgOfs) == cdp_pkg::PL_HDR1_OFS)
			|-> (prdata[19:16] == 4'h1 && prdata[15:0] == CONSORTIUM_ID);
	endproperty
	a_rev_vendor: assert property (p_rev_vendor) else $error("Revision or vendor field wrong");

	property p_vf_empty;
		@(posedge ref_clk) disable iff (!resetn)
		(access && vfAccess) |=> (pready && pslverr && prdata == 32'h0000_0000);
	endproperty
	a_vf_empty: assert property (p_vf_empty) else $error("Virtual function exposes a structure");

	property p_tl_only_f0;
		@(posedge ref_clk) disable iff (!resetn)
		(access && funcNum != '0 && !isAgentFunc) |=> pslverr;
	endproperty
	a_tl_only_f0: assert property (p_tl_only_f0) else $error("Structure answered outside function 0");

	property p_flr_keeps;
		@(posedge ref_clk) disable iff (!resetn)
		(flrReq && !doWrite) |=> (portCtrlQ == $past(portCtrlQ) && samBaseQ == $past(samBaseQ));
	endproperty
	a_flr_keeps: assert property (p_flr_keeps) else $error("Function level reset altered state");

	property p_set_wins;
		@(posedge ref_clk) disable iff (!resetn)
		linkErrEvt |=> rwStatusQ[cdp_pkg::ERR_EVT_BIT];
	endproperty
	a_set_wins: assert property (p_set_wins) else $error("Error event lost");

	property p_answer_time;
		@(posedge ref_clk) disable iff (!resetn)
		(psel && !penable) ##1 (psel && penable) |=> pready;
	endproperty
	a_answer_time: assert property (p_answer_time) else $error("Slave answer late");

	property p_primary_gate;
		@(posedge ref_clk) disable iff (!resetn)
		$rose(portCtrlQ[cdp_pkg::PRIMARY_EN_BIT]) |=> (primaryEnable == PRIMARY_CAPABLE)[*2];
	endproperty
	a_primary_gate: assert property (p_primary_gate) else $error("Primary enable wrong");

	property p_ptr_abs;
		@(posedge ref_clk) disable iff (!resetn)
		(pready && !pwrite && $past(isFunc0) && $past(cfgOfs) == cdp_pkg::TL_HDR_OFS)
			|-> prdata[31:20] == cdp_pkg::PL_HDR_OFS;
	endproperty
	a_ptr_abs: assert property (p_ptr_abs) else $error("Next pointer not to protocol header");

	property p_ro_write_err;
		@(posedge ref_clk) disable iff (!resetn)
		(access && pwrite && isFunc0 && (cfgOfs == cdp_pkg::CAP_COMMON_OFS || cfgOfs == cdp_pkg::STAT_RO_OFS))
			|=> (pready && pslverr);
	endproperty
	a_ro_write_err: assert property (p_ro_write_err) else $error("Read-only dword accepted a write");

	property p_rw1c_clear;
		@(posedge ref_clk) disable iff (!resetn)
		(doWrite && isFunc0 && cfgOfs == cdp_pkg::STAT_RW_OFS && pstrb[0] && pwdata[cdp_pkg::ERR_EVT_BIT] && !linkErrEvt)
			|=> !rwStatusQ[cdp_pkg::ERR_EVT_BIT];
	endproperty
	a_rw1c_clear: assert property (p_rw1c_clear) else $error("Write one did not clear status");

	property p_flr_keeps_tl;
		@(posedge ref_clk) disable iff (!resetn)
		(flrReq && !doWrite) |=> (tlCtrlQ == $past(tlCtrlQ) && commonCtrlQ == $past(commonCtrlQ));
	endproperty
	a_flr_keeps_tl: assert property (p_flr_keeps_tl) else $error("Function level reset altered control");

endmodule

// File: cdp_host_model.sv
// Host configuration software model: an APB master issuing configuration requests
`timescale 1ns/1ps
module cdp_host_model (
	input wire logic ref_clk,
	output logic psel,
	output logic penable,
	output logic pwrite,
	output logic [19:0] paddr,
	output logic [31:0] pwdata,
	output logic [3:0] pstrb,
	output logic vfAccess,
	input wire logic [31:0] prdata,
	input wire logic pready,
	input wire logic pslverr
);
	initial begin
		psel = 1'b0;
		penable = 1'b0;
		pwrite = 1'b0;
		paddr = 20'h00000;
		pwdata = 32'h0000_0000;
		pstrb = 4'hf;
		vfAccess = 1'b0;
	end
	// One whole word per request; a slave that never answers reports hung = 1
	task automatic xfer(input logic w, input logic [19:0] a, input logic [31:0] d, input logic vf,
		output logic [31:0] rdata, output logic err, output logic hung);
		int n;
		n = 0;
		hung = 1'b0;
		@(posedge ref_clk);
		psel <= 1'b1;
		penable <= 1'b0;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		vfAccess <= vf;
		@(posedge ref_clk);
		penable <= 1'b1;
		do begin
			@(posedge ref_clk);
			n++;
		end while (pready !== 1'b1 && n < 50);
		hung = (n >= 50);
		rdata = prdata;
		err = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
		// Released bus carries the inverse so stale values cannot match by chance
		pwdata <= ~d;
		paddr <= ~a;
	endtask
endmodule

// File: cdp_config_bank_bench.sv
// Self-checking bench of the configuration structure bank
`timescale 1ns/1ps
module cdp_config_bank_bench;
	localparam logic [15:0] CID = 16'h5a3c; // Arbitrary value
	localparam logic [3:0] PCNT = 4'h2;
	localparam logic [7:0] AFN = 8'hff;
	logic ref_clk = 1'b0;
	logic resetn = 1'b0;
	logic flrReq = 1'b0;
	logic linkErrEvt = 1'b0;
	logic [7:0] linkStatus = 8'ha5;
	logic psel, penable, pwrite, vfAccess, pready, pslverr, primaryEnable;
	logic [19:0] paddr;
	logic [31:0] pwdata, prdata, portControl, systemAddressMapBase;
	logic [3:0] pstrb;
	int errCount = 0;
	int nCompared = 0;
	always #20 ref_clk = ~ref_clk;
	cdp_host_model host_u (.ref_clk(ref_clk), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
		.pwdata(pwdata), .pstrb(pstrb), .vfAccess(vfAccess), .prdata(prdata), .pready(pready), .pslverr(pslverr));
	cdp_config_bank #(.CONSORTIUM_ID(CID), .PRIMARY_CAPABLE(1'b1), .PORT_COUNT(PCNT),
		.IS_BRIDGE_OR_COLLECTOR(1'b0), .FUNC_BITS(8), .AGENT_FUNC(AFN)) dut_u (
		.ref_clk(ref_clk), .resetn(resetn), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
		.pwdata(pwdata), .pstrb(pstrb), .vfAccess(vfAccess), .flrReq(flrReq), .linkErrEvt(linkErrEvt),
		.linkStatus(linkStatus), .prdata(prdata), .pready(pready), .pslverr(pslverr),
		.primaryEnable(primaryEnable), .portControl(portControl), .systemAddressMapBase(systemAddressMapBase));
	task automatic check(input logic [31:0] seen, input logic [31:0] exp);
		nCompared++;
		if (seen !== exp) begin
			errCount++;
			$display("MISMATCH t=%0t seen %h expected %h", $time, seen, exp);
		end
	endtask
	task automatic access(input logic w, input logic [7:0] fn, input logic [11:0] ofs, input logic [31:0] d,
		input logic vf, input logic [31:0] expData, input logic expErr, input logic cmpData);
		logic [31:0] rd;
		logic er, hg;
		host_u.xfer(w, {fn, ofs}, d, vf, rd, er, hg);
		check({31'h0, hg}, 32'h0);
		check({31'h0, er}, {31'h0, expErr});
		if (cmpData) check(rd, expData);
	endtask
	task automatic rd(input logic [7:0] fn, input logic [11:0] ofs, input logic [31:0] exp);
		access(1'b0, fn, ofs, 32'h0, 1'b0, exp, 1'b0, 1'b1);
	endtask
	task automatic test_headers;
		rd(8'h00, cdp_pkg::TL_HDR_OFS, {cdp_pkg::PL_HDR_OFS, cdp_pkg::CAP_VERSION, cdp_pkg::EXT_CAP_ID});
		rd(8'h00, cdp_pkg::TL_HDR1_OFS, {cdp_pkg::TL_LENGTH, cdp_pkg::STRUCT_REVISION, CID});
		rd(8'h00, cdp_pkg::PL_HDR_OFS, {cdp_pkg::NEXT_NONE, cdp_pkg::CAP_VERSION, cdp_pkg::EXT_CAP_ID});
		rd(8'h00, cdp_pkg::PL_HDR1_OFS, {cdp_pkg::PL_LENGTH, cdp_pkg::STRUCT_REVISION, CID});
		rd(8'h00, cdp_pkg::PL_HDR2_OFS, {16'h0000, cdp_pkg::PL_COMPONENT_ID});
		rd(8'h00, cdp_pkg::PL_PTR_OFS, {4'h0, cdp_pkg::CTRL_BASE_OFS, 4'h0, cdp_pkg::CAP_BASE_OFS});
		$display("test_headers done");
	endtask
	task automatic test_placement;
		// Highest function number holds the agent structures
		rd(AFN, cdp_pkg::AGENT0_HDR_OFS, {cdp_pkg::AGENT1_HDR_OFS, cdp_pkg::CAP_VERSION, cdp_pkg::EXT_CAP_ID});
		rd(AFN, cdp_pkg::AGENT0_HDR1_OFS, {cdp_pkg::AGENT_LENGTH, cdp_pkg::STRUCT_REVISION, CID});
		rd(AFN, cdp_pkg::AGENT1_HDR_OFS, {cdp_pkg::NEXT_NONE, cdp_pkg::CAP_VERSION, cdp_pkg::EXT_CAP_ID});
		rd(AFN, cdp_pkg::AGENT1_HDR1_OFS, {cdp_pkg::AGENT_LENGTH, cdp_pkg::STRUCT_REVISION, CID});
		access(1'b0, 8'h02, cdp_pkg::TL_HDR_OFS, 32'h0, 1'b0, 32'h0, 1'b1, 1'b0);
		access(1'b0, 8'h00, cdp_pkg::PL_HDR_OFS, 32'h0, 1'b1, 32'h0, 1'b1, 1'b0);
		access(1'b0, 8'h00, 12'h1f0, 32'h0, 1'b0, 32'h0, 1'b1, 1'b0);
		$display("test_placement done");
	endtask
	task automatic test_control;
		rd(8'h00, cdp_pkg::CAP_COMMON_OFS, {24'h0, PCNT, 3'b000, 1'b1});
		access(1'b1, 8'h00, cdp_pkg::CAP_COMMON_OFS, 32'hffff_fff0, 1'b0, 32'h0, 1'b1, 1'b0);
		rd(8'h00, cdp_pkg::CAP_COMMON_OFS, {24'h0, PCNT, 3'b000, 1'b1});
		rd(8'h00, cdp_pkg::STAT_RO_OFS, {24'h0, linkStatus});
		rd(8'h00, cdp_pkg::CAP_CHIP_OFS, 32'h0000_0001);
		access(1'b1, 8'h00, cdp_pkg::TL_CTRL_OFS, 32'h1234_5678, 1'b0, 32'h0, 1'b0, 1'b0);
		rd(8'h00, cdp_pkg::TL_CTRL_OFS, 32'h1234_5678);
		check({31'h0, primaryEnable}, 32'h0);
		// Only this port is ever made primary
		access(1'b1, 8'h00, cdp_pkg::CTRL_PORT_OFS, 32'h0000_0001, 1'b0, 32'h0, 1'b0, 1'b0);
		// Output copy is launched one edge after the write edge, so look one edge later
		repeat (2) @(posedge ref_clk);
		check({31'h0, primaryEnable}, 32'h1);
		check(portControl, 32'h0000_0001);
		access(1'b1, 8'h00, cdp_pkg::CTRL_SAM_OFS, 32'h8765_4320, 1'b0, 32'h0, 1'b0, 1'b0);
		access(1'b1, 8'h00, cdp_pkg::CTRL_COMMON_OFS, 32'h0000_00c3, 1'b0, 32'h0, 1'b0, 1'b0);
		rd(8'h00, cdp_pkg::CTRL_COMMON_OFS, 32'h0000_00c3);
		@(posedge ref_clk);
		check(systemAddressMapBase, 32'h8765_4320);
		$display("test_control done");
	endtask
	task automatic test_flr;
		@(posedge ref_clk);
		linkErrEvt <= 1'b1;
		flrReq <= 1'b1;
		@(posedge ref_clk);
		linkErrEvt <= 1'b0;
		flrReq <= 1'b0;
		rd(8'h00, cdp_pkg::STAT_RW_OFS, 32'h0000_0003);
		rd(8'h00, cdp_pkg::CTRL_PORT_OFS, 32'h0000_0001);
		rd(8'h00, cdp_pkg::CTRL_SAM_OFS, 32'h8765_4320);
		rd(8'h00, cdp_pkg::TL_CTRL_OFS, 32'h1234_5678);
		check({31'h0, primaryEnable}, 32'h1);
		// Write one clears only the flagged bit
		access(1'b1, 8'h00, cdp_pkg::STAT_RW_OFS, 32'h0000_0001, 1'b0, 32'h0, 1'b0, 1'b0);
		rd(8'h00, cdp_pkg::STAT_RW_OFS, 32'h0000_0002);
		$display("test_flr done");
	endtask
	task automatic complete_run;
		$display("compared %0d mismatches %0d", nCompared, errCount);
		if (errCount == 0 && nCompared > 0) begin
			$display("ALL CHECKS OK");
		end else begin
			$display("CHECKS NOT OK");
		end
		$finish;
	endtask
	initial begin
		repeat (20) @(posedge ref_clk);
		resetn <= 1'b1;
		test_headers();
		test_placement();
		test_control();
		test_flr();
		complete_run();
	end
	// Watchdog well beyond the 150 or so cycles the tests need
	initial begin
		#(40 * 5000);
		errCount++;
		complete_run();
	end
endmodule
